//--- inc/pmc_pkg.sv
/*
  Package for the power mode control block: register address, field
  positions, reset values, state enumeration and timing constants.
  Assumes a single system clock of 125 MHz and an SFR-style core port.
*/
package pmc_pkg;
  // Register address on the special-function bus
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  // Field positions
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  // Reset vector that the core fetches from after any reset
  localparam logic [16:0] RESET_VECTOR = 17'h00000;
  // Lost clock monitor timeout in microseconds and system clock rate
  localparam int LOST_CLOCK_TIMEOUT_US = 100;
  localparam int SYS_CLK_MHZ = 125;
  localparam int LOST_CLOCK_CYCLES = LOST_CLOCK_TIMEOUT_US * SYS_CLK_MHZ;
  // Reset pulse length issued to the rest of the chip, in cycles
  localparam int RESET_PULSE_CYCLES = 4;
  // Operating modes
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP
  } pmc_mode_e;
endpackage

//--- logic/pmc_sync.sv
/*
  Two flip-flop synchroniser for a single level from outside the clock domain.
  Assumes the input is a slowly changing active-low level such as a reset pin.
*/
`timescale 1ns/1ps
module pmc_sync (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic stage1; // First stage, read only by the second
  logic stage2; // Second stage, safe for logic

  // Capture then re-capture; no freeze so that a stopped block still sees pins.
  // Resets to the idle (high) level of an active-low pin, so leaving reset
  // does not look like a pin assertion and restart the reset pulse.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule

//--- logic/pmc_lost_clock.sv
/*
  Lost clock monitor timer. While armed and the oscillator is reported
  stopped, it counts towards the timeout and then pulses a reset request.
  Assumes it runs from a low-power always-on clock supplied as sys_clk_i.
*/
`timescale 1ns/1ps
module pmc_lost_clock #(
  parameter int TIMEOUT_CYCLES = pmc_pkg::LOST_CLOCK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic clock_missing_i,
  output logic timeout_o
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

  logic [CW-1:0] count; // Cycles the oscillator has been missing
  logic [CW-1:0] next_count;
  logic timeout; // Registered expiry pulse
  logic next_timeout;

  // Count while armed and clock missing; a present clock restarts the wait
  always_comb begin
    next_count = count;
    next_timeout = 1'b0;
    if (!enable_i || !clock_missing_i) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_timeout = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  // Registers only; runs even when the main clock enable is low by design
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= '0;
      timeout <= 1'b0;
    end else begin
      count <= next_count;
      timeout <= next_timeout;
    end
  end

  assign timeout_o = timeout;
endmodule

//--- logic/pmc_top.sv
/*
  Power mode control: holds the power control register, enters Idle or Stop
  after the writing instruction completes, gates CPU and system clocks,
  and ends Idle on interrupt or reset, Stop on reset only. Assumes a core that presents an
  SFR write with a strobe and reports instruction completion with a pulse.
*/
`timescale 1ns/1ps
module pmc_top #(
  parameter int TIMEOUT_CYCLES = pmc_pkg::LOST_CLOCK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic rst_pin_n_i,
  input wire logic watchdog_reset_i,
  input wire logic lost_clock_enable_i,
  input wire logic osc_stopped_i,
  output logic [7:0] sfr_rdata_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic irq_enable_o,
  output logic wake_irq_o,
  output logic sys_reset_o,
  output logic [16:0] reset_vector_o,
  output logic [1:0] mode_o
);
  localparam int RCW = $clog2(pmc_pkg::RESET_PULSE_CYCLES + 1);
  localparam logic [RCW-1:0] RST_LEN = RCW'(pmc_pkg::RESET_PULSE_CYCLES);

  pmc_pkg::pmc_mode_e mode; // Current power mode
  pmc_pkg::pmc_mode_e next_mode;
  logic idle_pend; // Idle requested, waiting for instruction end
  logic next_idle_pend;
  logic stop_pend; // Stop requested, waiting for instruction end
  logic next_stop_pend;
  logic [RCW-1:0] rst_cnt; // Remaining cycles of the reset pulse
  logic [RCW-1:0] next_rst_cnt;
  logic [7:0] rdata; // Read data register
  logic [7:0] next_rdata;
  logic cpu_clk_en;
  logic next_cpu_clk_en;
  logic periph_clk_en;
  logic next_periph_clk_en;
  logic osc_en;
  logic next_osc_en;
  logic irq_en;
  logic next_irq_en;
  logic wake_irq;
  logic next_wake_irq;
  logic sys_reset;
  logic next_sys_reset;
  logic pin_sync_n; // Reset pin after two flops
  logic mcd_timeout; // Lost clock monitor expiry pulse
  logic reset_event; // Any reset source this cycle
  logic pc_write; // Write to the power control register

  // Pin reset crosses into the clock domain before use
  pmc_sync u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(rst_pin_n_i),
    .sync_o(pin_sync_n)
  );

  // Monitor only armed while in Stop; elsewhere oscillator runs anyway
  pmc_lost_clock #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_lost_clock (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(lost_clock_enable_i && (mode == pmc_pkg::PMC_STOP)),
    .clock_missing_i(osc_stopped_i),
    .timeout_o(mcd_timeout)
  );

  // Address decode for the single register
  assign pc_write = sfr_wr_i && (sfr_addr_i == pmc_pkg::POWER_CONTROL_ADDR);

  // Internal or external reset; the watchdog runs on peripheral clock
  assign reset_event = !pin_sync_n || watchdog_reset_i || mcd_timeout;

  // Mode sequencing: request, wait for instruction end, enter, wake
  always_comb begin
    next_mode = mode;
    next_idle_pend = idle_pend;
    next_stop_pend = stop_pend;
    next_rst_cnt = rst_cnt;
    next_wake_irq = 1'b0;
    if (reset_event) begin
      // Any reset ends both modes and restarts the core
      next_mode = pmc_pkg::PMC_RUN;
      next_idle_pend = 1'b0;
      next_stop_pend = 1'b0;
      next_rst_cnt = RST_LEN;
    end else begin
      if (rst_cnt != '0) begin
        next_rst_cnt = rst_cnt - RCW'(1);
      end
      case (mode)
        pmc_pkg::PMC_RUN: begin
          if (pc_write && sfr_wdata_i[pmc_pkg::STOP_BIT]) begin
            next_stop_pend = 1'b1;
          end else if (pc_write && sfr_wdata_i[pmc_pkg::IDLE_BIT]) begin
            next_idle_pend = 1'b1;
          end
          // Entry waits for the writing instruction to complete
          if (instr_done_i && (stop_pend || next_stop_pend)) begin
            next_mode = pmc_pkg::PMC_STOP;
            next_stop_pend = 1'b0;
            next_idle_pend = 1'b0;
          end else if (instr_done_i && (idle_pend || next_idle_pend)) begin
            next_mode = pmc_pkg::PMC_IDLE;
            next_idle_pend = 1'b0;
          end
        end
        pmc_pkg::PMC_IDLE: begin
          // Interrupt wake raises the wake flag and resumes the CPU
          if (irq_pending_i) begin
            next_mode = pmc_pkg::PMC_RUN;
            next_wake_irq = 1'b1;
          end
        end
        pmc_pkg::PMC_STOP: begin
          // Interrupts are ignored; only a reset leaves Stop
          next_mode = pmc_pkg::PMC_STOP;
        end
        default: begin
          next_mode = pmc_pkg::PMC_RUN;
        end
      endcase
    end
  end

  // Clock and interrupt gating derived from the next mode
  always_comb begin
    // Idle stops only the CPU; CPU state is held, not reset
    next_cpu_clk_en = (next_mode == pmc_pkg::PMC_RUN);
    // Stop kills system clock, oscillators and interrupt logic
    next_periph_clk_en = (next_mode != pmc_pkg::PMC_STOP);
    next_osc_en = (next_mode != pmc_pkg::PMC_STOP);
    next_irq_en = (next_mode != pmc_pkg::PMC_STOP);
    next_sys_reset = (next_rst_cnt != '0);
  end

  // Read path: select bits always read zero, reserved bits zero too
  always_comb begin
    next_rdata = rdata;
    if (sfr_rd_i && (sfr_addr_i == pmc_pkg::POWER_CONTROL_ADDR)) begin
      next_rdata = pmc_pkg::POWER_CONTROL_RESET;
    end else if (sfr_rd_i) begin
      next_rdata = 8'h00;
    end
  end

  // State registers; clock enable freezes everything. Reset sources act
  // even in Stop because the clock enable is expected to be high then.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode <= pmc_pkg::PMC_RUN;
      idle_pend <= 1'b0;
      stop_pend <= 1'b0;
      rst_cnt <= RST_LEN;
      rdata <= pmc_pkg::POWER_CONTROL_RESET;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      irq_en <= 1'b1;
      wake_irq <= 1'b0;
      sys_reset <= 1'b1;
    end else if (clk_en_i) begin
      mode <= next_mode;
      idle_pend <= next_idle_pend;
      stop_pend <= next_stop_pend;
      rst_cnt <= next_rst_cnt;
      rdata <= next_rdata;
      cpu_clk_en <= next_cpu_clk_en;
      periph_clk_en <= next_periph_clk_en;
      osc_en <= next_osc_en;
      irq_en <= next_irq_en;
      wake_irq <= next_wake_irq;
      sys_reset <= next_sys_reset;
    end
  end

  assign sfr_rdata_o = rdata;
  assign cpu_clk_en_o = cpu_clk_en;
  assign periph_clk_en_o = periph_clk_en;
  assign osc_en_o = osc_en;
  assign irq_enable_o = irq_en;
  assign wake_irq_o = wake_irq;
  assign sys_reset_o = sys_reset;
  assign reset_vector_o = pmc_pkg::RESET_VECTOR;
  assign mode_o = mode;
endmodule

//--- dv/pmc_chk.sv
/* Checker for pmc_top: assertions over its ports, bound to every instance.
   Assumes one clock domain; properties that need progress require clk_en_i high. */
`timescale 1ns/1ps
module pmc_chk (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic rst_pin_n_i,
  input wire logic watchdog_reset_i,
  input wire logic lost_clock_enable_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_en_o,
  input wire logic irq_enable_o,
  input wire logic wake_irq_o,
  input wire logic sys_reset_o,
  input wire logic [1:0] mode_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Write that ends its instruction in Run; wake and reset sources quiet so the outcome is fixed
  logic pc_wr;
  assign pc_wr = clk_en_i && sfr_wr_i && instr_done_i && sfr_addr_i == 8'h87 && mode_o == 2'h0
    && !irq_pending_i && !watchdog_reset_i && rst_pin_n_i;
  // Wake steps: back in Run with exactly one cycle of the wake flag
  sequence s_woken;
    mode_o == 2'h0 && cpu_clk_en_o && wake_irq_o ##1 !wake_irq_o;
  endsequence
  a_idle_gates: assert property (
    mode_o == 2'h1 |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o && irq_enable_o)
    else $error("idle gating");
  a_stop_gates: assert property (
    mode_o == 2'h2 |-> !cpu_clk_en_o && !periph_clk_en_o && !osc_en_o && !irq_enable_o)
    else $error("stop gating");
  // The pin reaches the mode logic two flops late, so its last two samples count too
  a_idle_entry: assert property (
    pc_wr && $past(rst_pin_n_i) && $past(rst_pin_n_i, 2) && sfr_wdata_i[1:0] == 2'h1
    |=> mode_o == 2'h1) else $error("idle not entered");
  a_stop_entry: assert property (
    pc_wr && $past(rst_pin_n_i) && $past(rst_pin_n_i, 2) && sfr_wdata_i[1]
    |=> mode_o == 2'h2) else $error("stop not entered");
  a_irq_wake: assert property (
    mode_o == 2'h1 && irq_pending_i && clk_en_i && !watchdog_reset_i && rst_pin_n_i
    && $past(rst_pin_n_i) && $past(rst_pin_n_i, 2) |=> s_woken)
    else $error("interrupt wake wrong");
  a_stop_holds: assert property (
    mode_o == 2'h2 && rst_pin_n_i && $past(rst_pin_n_i) && $past(rst_pin_n_i, 2)
    && !watchdog_reset_i && !lost_clock_enable_i |=> mode_o == 2'h2)
    else $error("stop left without reset");
  a_wdog_reset: assert property (
    watchdog_reset_i && clk_en_i |=> mode_o == 2'h0 && sys_reset_o) else $error("watchdog reset");
  a_pin_reset: assert property (
    $fell(rst_pin_n_i) |-> ##[1:5] (mode_o == 2'h0 && sys_reset_o)) else $error("pin reset");
endmodule
bind pmc_top pmc_chk u_pmc_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
  .instr_done_i(instr_done_i), .irq_pending_i(irq_pending_i), .rst_pin_n_i(rst_pin_n_i),
  .watchdog_reset_i(watchdog_reset_i), .lost_clock_enable_i(lost_clock_enable_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .osc_en_o(osc_en_o),
  .irq_enable_o(irq_enable_o), .wake_irq_o(wake_irq_o), .sys_reset_o(sys_reset_o),
  .mode_o(mode_o));

//--- dv/pmc_core_model.sv
/* Core model: runs one SFR write or read instruction per task call.
   Assumes the power block samples its SFR inputs on the rising edge. */
`timescale 1ns/1ps
module pmc_core_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic instr_done_o
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    instr_done_o = 1'b0;
  end
  // Write in the first cycle; the instruction ends lag cycles later, 0 meaning the same cycle.
  // The following instruction is taken as multibyte and analog blocks as already shut off.
  task automatic exec_write(input logic [7:0] addr, input logic [7:0] data,
    input int lag);
    @(negedge sys_clk_i);
    sfr_addr_o = addr;
    sfr_wdata_o = data;
    sfr_wr_o = 1'b1;
    instr_done_o = (lag == 0);
    @(negedge sys_clk_i);
    // Released lines show the inverse, so a stale copy is never mistaken for data
    sfr_wr_o = 1'b0;
    sfr_addr_o = ~addr;
    sfr_wdata_o = ~data;
    instr_done_o = (lag == 1);
    if (lag > 1) begin
      repeat (lag - 1) @(negedge sys_clk_i);
      instr_done_o = 1'b1;
    end
    if (lag > 0) begin
      @(negedge sys_clk_i);
      instr_done_o = 1'b0;
    end
  endtask
  // Read strobe for one cycle; data is registered, so it is taken one cycle later
  task automatic exec_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk_i);
    sfr_addr_o = addr;
    sfr_rd_o = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~addr;
    @(negedge sys_clk_i);
    data = sfr_rdata_i;
  endtask
endmodule

//--- dv/power_mode_control_tb_top.sv
/* Testbench for pmc_top: the core model drives the SFR side, the bench the
   wake and reset sources. Assumes a shortened lost clock timeout. */
`timescale 1ns/1ps
module power_mode_control_tb_top;
  localparam int TMO = 20; // Short timeout keeps the run brief
  logic sys_clk, sys_rst, irq, pin_n, wdog, lost_en, osc_off;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic wr, rd, done, cpu_en, per_en, osc_en, irq_en, wake, sreset;
  logic clk_en; // Bench-driven clock enable, lowered once to check the freeze
  logic [16:0] vec;
  logic [1:0] mode;
  int miscompares = 0;
  int n_checks = 0;
  pmc_core_model core (.sys_clk_i(sys_clk), .sfr_rdata_i(rdata), .sfr_addr_o(addr),
    .sfr_wdata_o(wdata), .sfr_wr_o(wr), .sfr_rd_o(rd), .instr_done_o(done));
  // Clock enable is driven so that the freeze is exercised; it stays high in Stop
  pmc_top #(.TIMEOUT_CYCLES(TMO)) dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .clk_en_i(clk_en),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .instr_done_i(done),
    .irq_pending_i(irq), .rst_pin_n_i(pin_n), .watchdog_reset_i(wdog),
    .lost_clock_enable_i(lost_en), .osc_stopped_i(osc_off), .sfr_rdata_o(rdata),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_en_o(osc_en), .irq_enable_o(irq_en),
    .wake_irq_o(wake), .sys_reset_o(sreset), .reset_vector_o(vec), .mode_o(mode));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for a mode and reset level; running out ends the run
  task automatic wait_for(input logic [1:0] m, input logic r, input int bound);
    for (int i = 0; i < bound && (mode !== m || sreset !== r); i++)
      @(negedge sys_clk);
    if (mode !== m || sreset !== r) begin
      miscompares++;
      $display("[ERR] %0t ns: wait ran out", $time);
      summarize();
    end
  endtask
  task automatic t_reset();
    check(vec, 17'h00000);
    wait_for(2'h0, 1'b0, 12);
    core.exec_write(8'h87, 8'hfc, 0);
    check(mode, 2'h0);
    core.exec_read(8'h87, rd_val);
    check(rd_val, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_idle_irq();
    core.exec_write(8'h87, 8'h01, 2);
    check(mode, 2'h1);
    check({cpu_en, per_en, osc_en, irq_en}, 4'h7);
    core.exec_write(8'h87, 8'h02, 0);
    check(mode, 2'h1);
    // With the clock enable low the interrupt must wait and all state hold
    clk_en = 1'b0;
    irq = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({mode, cpu_en, wake}, 4'h4);
    clk_en = 1'b1;
    @(negedge sys_clk);
    check({mode, cpu_en, wake}, 4'h3);
    @(negedge sys_clk);
    irq = 1'b0;
    check(wake, 1'b0);
    $display("test idle wake done");
  endtask
  task automatic t_idle_resets();
    core.exec_write(8'h87, 8'h01, 0);
    check(mode, 2'h1);
    wdog = 1'b1;
    @(negedge sys_clk);
    wdog = 1'b0;
    check({mode, sreset}, 3'h1);
    wait_for(2'h0, 1'b0, 12);
    core.exec_write(8'h87, 8'h01, 1);
    check(mode, 2'h1);
    pin_n = 1'b0;
    wait_for(2'h0, 1'b1, 6);
    pin_n = 1'b1;
    wait_for(2'h0, 1'b0, 12);
    $display("test idle resets done");
  endtask
  task automatic t_stop();
    core.exec_write(8'h87, 8'h03, 3);
    check(mode, 2'h2);
    check({cpu_en, per_en, osc_en, irq_en}, 4'h0);
    irq = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(mode, 2'h2);
    irq = 1'b0;
    pin_n = 1'b0;
    wait_for(2'h0, 1'b1, 6);
    pin_n = 1'b1;
    wait_for(2'h0, 1'b0, 12);
    $display("test stop done");
  endtask
  // Monitor armed: Stop must last the whole timeout and end by reset right after it
  task automatic t_lost();
    lost_en = 1'b1;
    core.exec_write(8'h87, 8'h02, 0);
    check(mode, 2'h2);
    osc_off = 1'b1;
    repeat (TMO) @(negedge sys_clk);
    check(mode, 2'h2);
    wait_for(2'h0, 1'b1, 3);
    osc_off = 1'b0;
    lost_en = 1'b0;
    wait_for(2'h0, 1'b0, 12);
    $display("test lost clock done");
  endtask
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    irq = 1'b0;
    pin_n = 1'b1;
    wdog = 1'b0;
    lost_en = 1'b0;
    osc_off = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_idle_irq();
    t_idle_resets();
    t_stop();
    t_lost();
    summarize();
  end
endmodule
